// >>> scc_pkg.sv
package scc_pkg;
  // ==========================================================
  // register addresses
  localparam logic [7:0] EXT_OSC_CONTROL_ADDR = 8'hB1;
  localparam logic [7:0] INT_OSC_CONTROL_ADDR = 8'hB2;
  localparam logic [7:0] INT_OSC_CAL_ADDR     = 8'hB3;
  localparam logic [7:0] FLASH_TIMING_ADDR    = 8'hB6;
  // ==========================================================
  // field positions
  localparam int INT_EN_BIT      = 7;
  localparam int INT_RDY_BIT     = 6;
  localparam int INT_DIV_LSB     = 0;
  localparam int XTL_VALID_BIT   = 7;
  localparam int EXT_TYPE_LSB    = 4;
  localparam int EXT_FCTL_LSB    = 0;
  localparam int FLASH_RT_BIT    = 4;
  localparam int CAL_W           = 7;
  // ==========================================================
  // reset values
  localparam logic [7:0] INT_OSC_CONTROL_RST = 8'hC0;
  localparam logic [1:0] INT_DIV_RST         = 2'h0;
  localparam logic [2:0] EXT_TYPE_RST        = 3'h0;
  localparam logic [2:0] EXT_FCTL_RST        = 3'h0;
  localparam logic       FLASH_RT_RST        = 1'b0;
  // ==========================================================
  // external oscillator mode codes
  localparam logic [2:0] EXT_CMOS       = 3'h2;
  localparam logic [2:0] EXT_CMOS_HALF  = 3'h3;
  localparam logic [2:0] EXT_RC         = 3'h4;
  localparam logic [2:0] EXT_CAP        = 3'h5;
  localparam logic [2:0] EXT_XTAL       = 3'h6;
  localparam logic [2:0] EXT_XTAL_HALF  = 3'h7;
  // ==========================================================
  // divider ratios minus one
  localparam logic [2:0] EXT_DIV8_M1    = 3'h7;
  localparam logic [2:0] EXT_HALF_M1    = 3'h1;
  localparam logic [2:0] EXT_FULL_M1    = 3'h0;
  // ==========================================================
  // core clock sources
  typedef enum logic [1:0] {
    SRC_INTERNAL,
    SRC_EXTERNAL,
    SRC_MULTIPLIER,
    SRC_SPARE
  } scc_src_e;
endpackage : scc_pkg

// >>> scc_tick_div.sv
`timescale 1ns/1ps
module scc_tick_div
  import scc_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_ratio_m1,
  output logic              o_tick
);
  // ==========================================================
  // checks
  if (W < 1) begin : g_bad_w
    $error("scc_tick_div: W must be at least 1");
  end
  // ==========================================================
  // counter, ratio taken only at wrap so no short period
  logic [W-1:0] cnt_r;
  logic [W-1:0] ratio_r;
  logic [W-1:0] cnt_nxt;
  logic [W-1:0] ratio_nxt;
  logic         wrap;
  logic         tick_nxt;

  assign wrap      = i_tick && (cnt_r >= ratio_r);
  assign cnt_nxt   = !i_tick ? cnt_r : (wrap ? '0 : W'(cnt_r + 1'b1));
  assign ratio_nxt = wrap ? i_ratio_m1 : ratio_r;
  assign tick_nxt  = wrap;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r   <= '0;
      ratio_r <= '0;
      o_tick  <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      ratio_r <= ratio_nxt;
      o_tick  <= tick_nxt;
    end
  end
endmodule : scc_tick_div

// >>> scc_clock_ctrl.sv
`timescale 1ns/1ps
// Function
// RL1 - after reset the core clock runs from the internal oscillator
// RL2 - internal oscillator divided by 8, 4, 2 or 1 per divide select code
// RL3 - divide select resets to eight; control register resets to 11000000
// RL4 - control bit 7 enables the internal oscillator
// RL5 - bit 6 reads 1 only while internal oscillator runs at programmed rate
// RL6 - control bits 5 to 2 read zero and ignore writes
// RL7 - seven-bit calibration sets period; factory reset value; bit 7 reads zero
// RL8 - core clock chosen from internal, external or multiplier clocks
// RL9 - crystal modes claim both oscillator pins; other modes only second pin
// RL10 - software keeps crossbar off oscillator pins and sets their input mode
// RL11 - external clock divided by eight offered to timers and counter array
// RL12 - that divided clock is synchronised, jitter within half a core cycle
// RL13 - user keeps external clock no faster than core clock in that use
// RL14 - flash read time bit 4: 0 up to 25 MHz, 1 up to 50 MHz
// RL15 - flash timing reserved bits read zero, software writes zero
// RL16 - software picks oscillator type and frequency control before use
// RL17 - three-bit external mode field encodes off, cmos, rc, capacitor, crystal
// RL18 - crystal valid flag reads 1 only with crystal mode running stable
// RL19 - changing divide select never makes a shortened clock pulse
// RL20 - writes act on the next edge; reads show current flag state
module scc_clock_ctrl
  import scc_pkg::*;
#(
  parameter logic [CAL_W-1:0] CAL_RESET = 7'h40,
  parameter int               DIV_W     = 3
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rstn,
  input  wire logic [7:0]   i_sfr_addr,
  input  wire logic         i_sfr_wr,
  input  wire logic [7:0]   i_sfr_wdata,
  input  wire logic         i_sfr_rd,
  output logic [7:0]        o_sfr_rdata,
  input  wire logic         i_int_osc_tick,
  input  wire logic         i_int_osc_settled,
  input  wire logic         i_xtal_two_level,
  input  wire logic         i_xtal_stable,
  input  wire logic         i_mult_tick,
  input  wire logic [1:0]   i_core_src_sel,
  output logic              o_core_clk_en,
  output logic              o_ext_div8_en,
  output logic              o_int_osc_enable,
  output logic [CAL_W-1:0]  o_int_osc_cal,
  output logic [2:0]        o_ext_osc_type,
  output logic [2:0]        o_ext_freq_control,
  output logic              o_ext_drive_en,
  output logic              o_crystal_pin_one_used,
  output logic              o_crystal_pin_two_used,
  output logic              o_flash_read_time
);
  // ==========================================================
  // checks
  if (DIV_W < 3) begin : g_bad_div
    $error("scc_clock_ctrl: DIV_W must be at least 3");
  end

  // ==========================================================
  // decode
  function automatic logic [2:0] div_m1(input logic [1:0] code);
    case (code)
      2'h0:    div_m1 = 3'h7;
      2'h1:    div_m1 = 3'h3;
      2'h2:    div_m1 = 3'h1;
      default: div_m1 = 3'h0;
    endcase
  endfunction : div_m1

  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == EXT_XTAL) || (mode == EXT_XTAL_HALF);
  endfunction : is_crystal

  logic wr_int_ctl;
  logic wr_cal;
  logic wr_ext_ctl;
  logic wr_flash;
  assign wr_int_ctl = i_sfr_wr && (i_sfr_addr == INT_OSC_CONTROL_ADDR);
  assign wr_cal     = i_sfr_wr && (i_sfr_addr == INT_OSC_CAL_ADDR);
  assign wr_ext_ctl = i_sfr_wr && (i_sfr_addr == EXT_OSC_CONTROL_ADDR);
  assign wr_flash   = i_sfr_wr && (i_sfr_addr == FLASH_TIMING_ADDR);

  // ==========================================================
  // registers
  logic             int_en_r;
  logic [1:0]       int_div_r;
  logic [CAL_W-1:0] cal_r;
  logic [2:0]       ext_type_r;
  logic [2:0]       ext_fctl_r;
  logic             flash_rt_r;
  logic             int_rdy_r;
  logic             xtl_valid_r;

  logic             int_en_nxt;
  logic [1:0]       int_div_nxt;
  logic [CAL_W-1:0] cal_nxt;
  logic [2:0]       ext_type_nxt;
  logic [2:0]       ext_fctl_nxt;
  logic             flash_rt_nxt;
  logic             int_rdy_nxt;
  logic             xtl_valid_nxt;

  assign int_en_nxt   = wr_int_ctl ? i_sfr_wdata[INT_EN_BIT] : int_en_r; // see RL4 RL20
  assign int_div_nxt  = wr_int_ctl ? i_sfr_wdata[INT_DIV_LSB +: 2] : int_div_r; // see RL2
  assign cal_nxt      = wr_cal ? i_sfr_wdata[CAL_W-1:0] : cal_r; // see RL7
  assign ext_type_nxt = wr_ext_ctl ? i_sfr_wdata[EXT_TYPE_LSB +: 3] : ext_type_r; // see RL17
  assign ext_fctl_nxt = wr_ext_ctl ? i_sfr_wdata[EXT_FCTL_LSB +: 3] : ext_fctl_r;
  assign flash_rt_nxt = wr_flash ? i_sfr_wdata[FLASH_RT_BIT] : flash_rt_r; // see RL14 RL15

  // ready needs the oscillator enabled and settled at its set rate
  assign int_rdy_nxt   = int_en_nxt && i_int_osc_settled && !wr_cal; // see RL5
  // crystal valid only in crystal modes with amplitude detector stable
  assign xtl_valid_nxt = is_crystal(ext_type_nxt) && i_xtal_stable; // see RL18

  // cal is loaded with a fixed constant only; no port value under reset
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      int_en_r    <= INT_OSC_CONTROL_RST[INT_EN_BIT]; // see RL3
      int_div_r   <= INT_DIV_RST; // see RL3
      cal_r       <= CAL_RESET; // see RL7
      ext_type_r  <= EXT_TYPE_RST;
      ext_fctl_r  <= EXT_FCTL_RST;
      flash_rt_r  <= FLASH_RT_RST;
      int_rdy_r   <= INT_OSC_CONTROL_RST[INT_RDY_BIT]; // see RL3
      xtl_valid_r <= 1'b0;
    end else begin
      int_en_r    <= int_en_nxt;
      int_div_r   <= int_div_nxt;
      cal_r       <= cal_nxt;
      ext_type_r  <= ext_type_nxt;
      ext_fctl_r  <= ext_fctl_nxt;
      flash_rt_r  <= flash_rt_nxt;
      int_rdy_r   <= int_rdy_nxt;
      xtl_valid_r <= xtl_valid_nxt;
    end
  end

  // ==========================================================
  // read back
  logic [7:0] rd_int_ctl;
  logic [7:0] rd_cal;
  logic [7:0] rd_ext_ctl;
  logic [7:0] rd_flash;
  logic [7:0] rd_mux;
  assign rd_int_ctl = {int_en_r, int_rdy_r, 4'h0, int_div_r}; // see RL4 RL5 RL6
  assign rd_cal     = {1'b0, cal_r}; // see RL7
  assign rd_ext_ctl = {xtl_valid_r, ext_type_r, 1'b0, ext_fctl_r};
  assign rd_flash   = {3'h0, flash_rt_r, 4'h0}; // see RL15
  assign rd_mux     = (i_sfr_addr == INT_OSC_CONTROL_ADDR) ? rd_int_ctl :
                      (i_sfr_addr == INT_OSC_CAL_ADDR)     ? rd_cal     :
                      (i_sfr_addr == EXT_OSC_CONTROL_ADDR) ? rd_ext_ctl :
                      (i_sfr_addr == FLASH_TIMING_ADDR)    ? rd_flash   : 8'h00;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rd_mux; // see RL20
    end
  end

  // ==========================================================
  // internal oscillator path
  logic             int_tick;
  logic             int_div_tick;
  logic [DIV_W-1:0] int_ratio;
  assign int_tick  = i_int_osc_tick && int_en_r; // see RL4
  assign int_ratio = DIV_W'(div_m1(int_div_r)); // see RL2

  scc_tick_div #(.W(DIV_W)) u_int_div (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (i_rstn),
    .i_tick     (int_tick),
    .i_ratio_m1 (int_ratio),
    .o_tick     (int_div_tick)
  ); // see RL19

  // ==========================================================
  // external oscillator path
  logic       ext_on;
  logic       ext_half;
  logic       ext_lvl_r;
  logic       ext_edge;
  logic       ext_tick;
  logic       ext_div8_tick;
  logic [2:0] ext_ratio;
  assign ext_on    = ext_type_r[2] || ext_type_r[1]; // see RL17
  assign ext_half  = (ext_type_r == EXT_CMOS_HALF) || (ext_type_r == EXT_XTAL_HALF);
  assign ext_ratio = ext_half ? EXT_HALF_M1 : EXT_FULL_M1;
  assign ext_edge  = ext_on && i_xtal_two_level && !ext_lvl_r;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_lvl_r <= 1'b0;
    end else begin
      ext_lvl_r <= i_xtal_two_level;
    end
  end

  scc_tick_div #(.W(3)) u_ext_half (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (i_rstn),
    .i_tick     (ext_edge),
    .i_ratio_m1 (ext_ratio),
    .o_tick     (ext_tick)
  );

  // each pulse lands on an i_sys_clk edge, so jitter stays inside one cycle
  scc_tick_div #(.W(3)) u_ext_div8 (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (i_rstn),
    .i_tick     (ext_tick),
    .i_ratio_m1 (EXT_DIV8_M1),
    .o_tick     (ext_div8_tick)
  ); // see RL11 RL12

  // ==========================================================
  // core clock source select
  scc_src_e src;
  logic     core_nxt;
  assign src = scc_src_e'(i_core_src_sel);
  always_comb begin
    case (src)
      SRC_INTERNAL:   core_nxt = int_div_tick; // see RL1
      SRC_EXTERNAL:   core_nxt = ext_tick; // see RL8
      SRC_MULTIPLIER: core_nxt = i_mult_tick;
      default:        core_nxt = int_div_tick;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_core_clk_en <= 1'b0;
      o_ext_div8_en <= 1'b0;
    end else begin
      o_core_clk_en <= core_nxt;
      o_ext_div8_en <= ext_div8_tick;
    end
  end

  // ==========================================================
  // outputs
  assign o_int_osc_enable       = int_en_r;
  assign o_int_osc_cal          = cal_r;
  assign o_ext_osc_type         = ext_type_r;
  assign o_ext_freq_control     = ext_fctl_r;
  assign o_ext_drive_en         = ext_on;
  assign o_crystal_pin_one_used = is_crystal(ext_type_r); // see RL9
  assign o_crystal_pin_two_used = ext_on; // see RL9
  assign o_flash_read_time      = flash_rt_r; // see RL14
endmodule : scc_clock_ctrl

// >>> scc_clock_ctrl_asserts.sv
`timescale 1ns/1ps
module scc_clock_ctrl_asserts
  import scc_pkg::*;
(
  input wire logic             i_sys_clk,
  input wire logic             i_rstn,
  input wire logic [7:0]       i_sfr_addr,
  input wire logic             i_sfr_wr,
  input wire logic [7:0]       i_sfr_wdata,
  input wire logic             i_sfr_rd,
  input wire logic [7:0]       o_sfr_rdata,
  input wire logic             i_int_osc_tick,
  input wire logic [1:0]       i_core_src_sel,
  input wire logic             o_core_clk_en,
  input wire logic             o_ext_div8_en,
  input wire logic             o_int_osc_enable,
  input wire logic [CAL_W-1:0] o_int_osc_cal,
  input wire logic [2:0]       o_ext_osc_type,
  input wire logic             o_ext_drive_en,
  input wire logic             o_crystal_pin_one_used,
  input wire logic             o_crystal_pin_two_used,
  input wire logic             o_flash_read_time
);
  // ======
  // decode
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  wire             rd_ctl = i_sfr_rd && i_sfr_addr == INT_OSC_CONTROL_ADDR;
  wire             wr_ctl = i_sfr_wr && i_sfr_addr == INT_OSC_CONTROL_ADDR;
  wire             mapped = i_sfr_addr inside {EXT_OSC_CONTROL_ADDR, INT_OSC_CONTROL_ADDR,
                                               INT_OSC_CAL_ADDR, FLASH_TIMING_ADDR};
  wire             w_en   = i_sfr_wdata[INT_EN_BIT];
  wire             w_frt  = i_sfr_wdata[FLASH_RT_BIT];
  wire [CAL_W-1:0] w_cal  = i_sfr_wdata[CAL_W-1:0];
  // ======
  // assertions
  a_ctrl_unused_zero: assert property (rd_ctl |=> o_sfr_rdata[5:2] == 4'h0)
    else $error("control unused bits not zero");
  a_ready_needs_en: assert property (rd_ctl && !o_int_osc_enable &&
    !$past(o_int_osc_enable) |=> !o_sfr_rdata[INT_RDY_BIT]) else $error("ready while disabled");
  a_core_tick_cause: assert property (o_core_clk_en && $past(i_core_src_sel, 2) == 2'h0 &&
    $past(i_core_src_sel) == 2'h0 |-> $past(i_int_osc_tick, 2)) else $error("core tick uncaused");
  a_div8_spacing: assert property ($rose(o_ext_div8_en) |=> !o_ext_div8_en [*8])
    else $error("divided clock pulses too close");
  a_ext_drive_map: assert property (o_ext_drive_en == (o_ext_osc_type[2:1] != 2'h0) &&
    o_crystal_pin_two_used == o_ext_drive_en) else $error("drive enable decode wrong");
  a_pin_one_map: assert property (o_crystal_pin_one_used == (o_ext_osc_type[2:1] == 2'h3))
    else $error("first pin use decode wrong");
  a_enable_write: assert property (wr_ctl |=> o_int_osc_enable == $past(w_en))
    else $error("enable not written");
  a_enable_readback: assert property (rd_ctl |=> o_sfr_rdata[INT_EN_BIT] == $past(o_int_osc_enable))
    else $error("enable bit read back wrong");
  a_cal_write: assert property (i_sfr_wr && i_sfr_addr == INT_OSC_CAL_ADDR
    |=> o_int_osc_cal == $past(w_cal)) else $error("calibration not written");
  a_flash_write: assert property (i_sfr_wr && i_sfr_addr == FLASH_TIMING_ADDR
    |=> o_flash_read_time == $past(w_frt)) else $error("read time not written");
  a_flash_reserved: assert property (i_sfr_rd && i_sfr_addr == FLASH_TIMING_ADDR
    |=> {o_sfr_rdata[7:5], o_sfr_rdata[3:0]} == 7'h00) else $error("flash reserved not zero");
  a_unmapped_read: assert property (i_sfr_rd && !mapped |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  c_ctrl_read: cover property (rd_ctl);
  c_div8_pulse: cover property (o_ext_div8_en);
  c_ext_core: cover property (o_core_clk_en && i_core_src_sel == 2'h1);
endmodule : scc_clock_ctrl_asserts

bind scc_clock_ctrl scc_clock_ctrl_asserts u_chk (.i_sys_clk, .i_rstn, .i_sfr_addr, .i_sfr_wr,
  .i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata, .i_int_osc_tick, .i_core_src_sel, .o_core_clk_en,
  .o_ext_div8_en, .o_int_osc_enable, .o_int_osc_cal, .o_ext_osc_type, .o_ext_drive_en,
  .o_crystal_pin_one_used, .o_crystal_pin_two_used, .o_flash_read_time);

// >>> scc_ext_osc_model.sv
`timescale 1ns/1ps
module scc_ext_osc_model #(
  parameter int HALF   = 3,
  parameter int SETTLE = 4
) (
  input  wire logic i_sys_clk,
  input  wire logic i_drive_en,
  input  wire logic i_crystal_mode,
  output logic      o_pin_level,
  output logic      o_stable
);
  int ph  = 0;
  int age = 0;
  // ======
  // oscillation, still while drive is off
  always @(posedge i_sys_clk) begin
    ph <= (!i_drive_en || ph == 2 * HALF - 1) ? 0 : ph + 1;
    o_pin_level <= #1 i_drive_en && ph < HALF;
    age <= i_crystal_mode ? age + int'(age < SETTLE) : 0;
    o_stable <= #1 i_crystal_mode && age >= SETTLE;
  end
endmodule : scc_ext_osc_model

// >>> scc_clock_ctrl_tb.sv
`timescale 1ns/1ps
module scc_clock_ctrl_tb
  import scc_pkg::*;
;
  logic       clk, rstn, wr, rd, tick, settled, pin, stable;
  logic       core_en, div8_en, en, drv, p1, p2, frt;
  logic [1:0] src;
  logic [2:0] typ, fctl;
  logic [6:0] cal;
  logic [7:0] addr, wdata, rdata;
  int         fails = 0;
  int         total_checks = 0;
  int         mc = 0;
  // ======
  // design and far side
  scc_clock_ctrl #(.CAL_RESET(7'h40)) i_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
    .i_int_osc_tick(tick), .i_int_osc_settled(settled), .i_xtal_two_level(pin),
    .i_xtal_stable(stable), .i_mult_tick(mc == 0), .i_core_src_sel(src), .o_core_clk_en(core_en),
    .o_ext_div8_en(div8_en), .o_int_osc_enable(en), .o_int_osc_cal(cal), .o_ext_osc_type(typ),
    .o_ext_freq_control(fctl), .o_ext_drive_en(drv), .o_crystal_pin_one_used(p1),
    .o_crystal_pin_two_used(p2), .o_flash_read_time(frt));
  scc_ext_osc_model i_osc (.i_sys_clk(clk), .i_drive_en(drv), .i_crystal_mode(p1),
    .o_pin_level(pin), .o_stable(stable));
  // ======
  // tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(posedge clk) #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask : acc
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    check(rdata, exp);
  endtask : rd_chk
  task automatic gap_chk(input bit sel, input logic [7:0] exp);
    int g;
    repeat (3) begin
      g = 0;
      do begin
        @(posedge clk) #1;
        g++;
      end while ((sel ? div8_en : core_en) !== 1'b1 && g < 200);
    end
    check(8'(g), exp);
  endtask : gap_chk
  // ======
  // stimulus
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) tick <= #1 ~tick;
  always @(posedge clk) mc <= #1 (mc + 1) % 3;
  initial begin
    repeat (10000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    {rstn, wr, rd, tick, addr, wdata, src} = '0;
    settled = 1'b1;
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    rd_chk(INT_OSC_CONTROL_ADDR, 8'hC0);
    rd_chk(INT_OSC_CAL_ADDR, 8'h40);
    rd_chk(FLASH_TIMING_ADDR, 8'h00);
    rd_chk(EXT_OSC_CONTROL_ADDR, 8'h00);
    gap_chk(1'b0, 8'd16);
    $display("test reset values done");
    settled = 1'b0;
    acc(1'b1, INT_OSC_CONTROL_ADDR, 8'hFF);
    rd_chk(INT_OSC_CONTROL_ADDR, 8'h83);
    settled = 1'b1;
    rd_chk(INT_OSC_CONTROL_ADDR, 8'hC3);
    acc(1'b1, INT_OSC_CONTROL_ADDR, 8'h7C);
    rd_chk(INT_OSC_CONTROL_ADDR, 8'h00);
    check({7'h0, en}, 8'h00);
    acc(1'b1, INT_OSC_CAL_ADDR, 8'hFF);
    rd_chk(INT_OSC_CAL_ADDR, 8'h7F);
    check({1'b0, cal}, 8'h7F);
    acc(1'b1, FLASH_TIMING_ADDR, 8'hFF);
    rd_chk(FLASH_TIMING_ADDR, 8'h10);
    check({7'h0, frt}, 8'h01);
    acc(1'b1, 8'hB4, 8'hFF);
    rd_chk(8'hB4, 8'h00);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, INT_OSC_CONTROL_ADDR, {6'h20, c[1:0]});
      gap_chk(1'b0, 8'(16 >> c));
    end
    $display("test divider done");
    for (int m = 0; m < 8; m++) begin
      acc(1'b1, EXT_OSC_CONTROL_ADDR, {1'b1, m[2:0], 4'hD});
      repeat (8) @(posedge clk);
      rd_chk(EXT_OSC_CONTROL_ADDR, {m[2:1] == 2'h3, m[2:0], 4'h5});
      check({5'h0, drv, p1, p2}, {5'h0, m[2:1] != 2'h0, m[2:1] == 2'h3, m[2:1] != 2'h0});
      check({2'h0, typ, fctl}, {2'h0, m[2:0], 3'h5});
    end
    $display("test external modes done");
    acc(1'b1, EXT_OSC_CONTROL_ADDR, {1'b0, EXT_CMOS, 4'h0});
    gap_chk(1'b1, 8'd48);
    src = 2'h1;
    gap_chk(1'b0, 8'd6);
    acc(1'b1, EXT_OSC_CONTROL_ADDR, {1'b0, EXT_CMOS_HALF, 4'h0});
    gap_chk(1'b0, 8'd12);
    gap_chk(1'b1, 8'd96);
    src = 2'h2;
    gap_chk(1'b0, 8'd3);
    src = 2'h3;
    gap_chk(1'b0, 8'd2);
    $display("test clock sources done");
    src = 2'h0;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    rd_chk(INT_OSC_CONTROL_ADDR, 8'hC0);
    rd_chk(EXT_OSC_CONTROL_ADDR, 8'h00);
    check({1'b0, cal}, 8'h40);
    gap_chk(1'b0, 8'd16);
    $display("test second reset done");
    print_verdict();
  end
endmodule : scc_clock_ctrl_tb
